// ---- hw/dptov_derive.sv ----
// derives the automatic timing values from the lane bit rate
`timescale 1ns/1ns
`default_nettype none
`include "dptov_map.svh"

module dptov_derive
	import dptov_pkg::*;
(
	input  wire logic           mclk,
	input  wire logic           rst_n,
	input  wire dptov_rate_type rate,
	output logic [6:0]          auto_hs_zero,
	output logic [6:0]          auto_hs_trail,
	output logic [6:0]          auto_hs_exit,
	output logic [6:0]          auto_lp_exit,
	output logic                rate_changed
);

	// byte-clock counts per rate; one table keeps all four parameters aligned
	function automatic logic [27:0] derive_table(input dptov_rate_type r);
		unique case (r)
			DPTOV_RATE_400M:  derive_table = {7'h0A, 7'h06, 7'h08, 7'h04};
			DPTOV_RATE_800M:  derive_table = {7'h14, 7'h0B, 7'h0F, 7'h06};
			DPTOV_RATE_1500M: derive_table = {7'h25, 7'h14, 7'h1D, 7'h0B};
			DPTOV_RATE_1600M: derive_table = {7'h28, 7'h15, 7'h1F, 7'h0C};
		endcase
	endfunction

	wire logic [27:0] nxt_table = derive_table(rate);
	logic [27:0]      table_ff;
	dptov_rate_type   rate_ff;

	assign rate_changed = (rate != rate_ff);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			table_ff <= 28'h0000000;
			rate_ff  <= DPTOV_RATE_400M;
		end else begin
			table_ff <= nxt_table;
			rate_ff  <= rate;
		end
	end

	assign auto_hs_zero  = table_ff[27:21];
	assign auto_hs_trail = table_ff[20:14];
	assign auto_hs_exit  = table_ff[13:7];
	assign auto_lp_exit  = table_ff[6:0];

endmodule // dptov_derive

`default_nettype wire

// ---- hw/dptov_field.sv ----
// one timing register: override bit plus value that is storage or derived status
`timescale 1ns/1ns
`default_nettype none
`include "dptov_map.svh"

module dptov_field (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic [6:0] auto_value,
	output logic [7:0]      rd_data,
	output logic [6:0]      applied,
	output logic            override
);

	logic       override_ff;
	logic [6:0] value_ff;
	wire logic  nxt_override = wr_en ? wr_data[`DPTOV_BIT_OVERRIDE] : override_ff;
	// value only stores from a write whose override bit is set; the same write that sets
	// the bit also loads the value, so software can take over in one access
	wire logic  value_we     = wr_en & nxt_override;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			override_ff <= `DPTOV_RST_OVERRIDE;
			value_ff    <= `DPTOV_RST_VALUE;
		end else begin
			override_ff <= nxt_override;
			if (value_we)
				value_ff <= wr_data[`DPTOV_VAL_MSB:0];
			else if (!override_ff)
				value_ff <= auto_value;
		end
	end

	assign override = override_ff;
	assign applied  = override_ff ? value_ff : auto_value;
	assign rd_data  = {override_ff, applied};

endmodule // dptov_field

`default_nettype wire

// ---- hw/dptov_map.svh ----
// register offsets, field positions, reset values and the timing register count for the timing bank
`ifndef DPTOV_MAP_SVH
`define DPTOV_MAP_SVH

`define DPTOV_PAGE_TIMING       8'h00
`define DPTOV_OFS_HS_ZERO       8'h45
`define DPTOV_OFS_HS_TRAIL      8'h46
`define DPTOV_OFS_HS_EXIT       8'h47
`define DPTOV_OFS_LP_EXIT       8'h48
`define DPTOV_OFS_RATE          8'h49
`define DPTOV_OFS_PAGE          8'h4A
`define DPTOV_OFS_STATUS        8'h4B
`define DPTOV_BIT_OVERRIDE      7
`define DPTOV_VAL_MSB           6
`define DPTOV_RST_OVERRIDE      1'h0
`define DPTOV_RST_VALUE         7'h00
`define DPTOV_RST_RATE          2'h0
`define DPTOV_RST_PAGE          8'h00
`define DPTOV_NUM_TIMING        4

`endif

// ---- hw/dptov_pkg.sv ----
// types shared by the timing override bank
`default_nettype none

package dptov_pkg;

	typedef enum logic [1:0] {
		DPTOV_RATE_400M  = 2'b00,
		DPTOV_RATE_800M  = 2'b01,
		DPTOV_RATE_1500M = 2'b10,
		DPTOV_RATE_1600M = 2'b11
	} dptov_rate_type;

	typedef enum logic [1:0] {
		DPTOV_T_HS_ZERO  = 2'b00,
		DPTOV_T_HS_TRAIL = 2'b01,
		DPTOV_T_HS_EXIT  = 2'b10,
		DPTOV_T_LP_EXIT  = 2'b11
	} dptov_timing_type;

	typedef enum logic [1:0] {
		DPTOV_ST_IDLE  = 2'b00,
		DPTOV_ST_WAIT  = 2'b01,
		DPTOV_ST_RESP  = 2'b10
	} dptov_bus_state_type;

endpackage : dptov_pkg

`default_nettype wire

// ---- hw/dptov_regs.sv ----
// d-phy timing override register bank behind an avalon-mm slave with waitrequest
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dptov_map.svh"

// Behaviour
// - hs-zero bit 7 selects auto or value
// - hs-zero value read-only derived unless overridden
// - hs-trail override selects source and access
// - hs-exit override; reads derived when not overridden
// - lp-exit bit 7 selects auto or value
// - lp-exit value read-only derived unless overridden
// - all override bits reset to zero
// - registers at 0x45..0x48 of page 0x00
module dptov_regs
	import dptov_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [6:0]       hs_zero_applied,
	output logic [6:0]       hs_trail_applied,
	output logic [6:0]       hs_exit_applied,
	output logic [6:0]       lp_exit_applied
);

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, answer on the second

	dptov_bus_state_type state_ff;
	dptov_bus_state_type nxt_state;
	wire logic           req = avs_read | avs_write;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			DPTOV_ST_IDLE: if (req) nxt_state = DPTOV_ST_RESP;
			DPTOV_ST_RESP: nxt_state = DPTOV_ST_IDLE;
			default:       nxt_state = DPTOV_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			state_ff <= DPTOV_ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	wire logic accept = (state_ff == DPTOV_ST_RESP) & req;
	assign avs_waitrequest = req & (state_ff != DPTOV_ST_RESP);

	////////////////////////////////////////////////////////////////////////
	// page select and rate configuration

	logic [7:0]     page_ff;
	dptov_rate_type rate_ff;
	wire logic      be0      = avs_byteenable[0];
	wire logic      wr_ok    = accept & avs_write & be0;
	wire logic      on_page  = (page_ff == `DPTOV_PAGE_TIMING);
	wire logic      sel_page = (avs_address == `DPTOV_OFS_PAGE);
	wire logic      sel_rate = (avs_address == `DPTOV_OFS_RATE);
	wire logic      sel_stat = (avs_address == `DPTOV_OFS_STATUS);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			page_ff <= `DPTOV_RST_PAGE;
			rate_ff <= DPTOV_RATE_400M;
		end else begin
			if (wr_ok & sel_page)
				page_ff <= avs_writedata[7:0];
			if (wr_ok & sel_rate)
				rate_ff <= dptov_rate_type'(avs_writedata[1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// derivation and the four timing registers

	logic [6:0] auto_val [`DPTOV_NUM_TIMING];
	logic [6:0] applied  [`DPTOV_NUM_TIMING];
	logic [7:0] reg_rd   [`DPTOV_NUM_TIMING];
	logic [3:0] ovr;
	logic       rate_changed;

	dptov_derive u_derive (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.rate          (rate_ff),
		.auto_hs_zero  (auto_val[0]),
		.auto_hs_trail (auto_val[1]),
		.auto_hs_exit  (auto_val[2]),
		.auto_lp_exit  (auto_val[3]),
		.rate_changed  (rate_changed)
	);

	// timing index from offset; only valid when timing hit is high
	function automatic logic [1:0] timing_index(input logic [7:0] a);
		timing_index = 2'(a - `DPTOV_OFS_HS_ZERO);
	endfunction

	wire logic       sel_tim = on_page & (avs_address >= `DPTOV_OFS_HS_ZERO)
		& (avs_address <= `DPTOV_OFS_LP_EXIT);
	wire logic [1:0] tim_idx = timing_index(avs_address);

	genvar gi;
	generate
		for (gi = 0; gi < `DPTOV_NUM_TIMING; gi++) begin : g_tim
			dptov_field u_field (
				.mclk       (mclk),
				.rst_n      (rst_n),
				.wr_en      (wr_ok & sel_tim & (tim_idx == 2'(gi))),
				.wr_data    (avs_writedata[7:0]),
				.auto_value (auto_val[gi]),
				.rd_data    (reg_rd[gi]),
				.applied    (applied[gi]),
				.override   (ovr[gi])
			);
		end
	endgenerate

	assign hs_zero_applied  = applied[0];
	assign hs_trail_applied = applied[1];
	assign hs_exit_applied  = applied[2];
	assign lp_exit_applied  = applied[3];

	////////////////////////////////////////////////////////////////////////
	// read data; unmapped offsets read zero

	logic [7:0] rd_mux;
	logic       rate_seen_ff;

	always_comb begin
		rd_mux = 8'h00;
		if (sel_tim)
			rd_mux = reg_rd[tim_idx];
		else if (sel_page)
			rd_mux = page_ff;
		else if (sel_rate)
			rd_mux = {6'h00, rate_ff};
		else if (sel_stat)
			rd_mux = {3'h0, rate_seen_ff, ovr};
	end

	// sticky: rate changed since last status read; set wins over read clear
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rate_seen_ff <= 1'h0;
		else if (rate_changed)
			rate_seen_ff <= 1'h1;
		else if (accept & avs_read & sel_stat)
			rate_seen_ff <= 1'h0;
	end

	logic [31:0] readdata_ff;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			readdata_ff <= 32'h00000000;
		else if (req & (state_ff == DPTOV_ST_IDLE) & avs_read)
			readdata_ff <= {24'h000000, rd_mux};
	end

	assign avs_readdata = readdata_ff;

endmodule // dptov_regs

`default_nettype wire

// ---- tb/dptov_properties.sv ----
// concurrent checks for the timing override bank
`timescale 1ns/1ns
`default_nettype none
module dptov_properties (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [6:0]  hs_zero_applied,
	input wire logic [6:0]  hs_trail_applied,
	input wire logic [6:0]  hs_exit_applied,
	input wire logic [6:0]  lp_exit_applied
);
	logic [7:0] pg_ff;
	logic [6:0] wv_ff;
	wire        wa = avs_write && !avs_waitrequest;
	wire        rp = avs_read && !avs_waitrequest && pg_ff == 8'h00;
	wire        ov = wa && avs_byteenable[0] && pg_ff == 8'h00 && avs_writedata[7];
	// page shadow, so timing checks only fire where the bank is visible
	always_ff @(posedge mclk) begin
		if (!rst_n)
			pg_ff <= 8'h00;
		else if (wa && avs_byteenable[0] && avs_address == 8'h4A)
			pg_ff <= avs_writedata[7:0];
		wv_ff <= avs_writedata[6:0];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
		!avs_waitrequest) else $error("wait not exactly one cycle");
	AST_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address > 8'h4B |->
		avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_HSZ_OVR: assert property (ov && avs_address == 8'h45 |=>
		hs_zero_applied == wv_ff) else $error("hs zero override not applied");
	AST_HST_OVR: assert property (ov && avs_address == 8'h46 |=>
		hs_trail_applied == wv_ff) else $error("hs trail override not applied");
	AST_HSX_OVR: assert property (ov && avs_address == 8'h47 |=>
		hs_exit_applied == wv_ff) else $error("hs exit override not applied");
	AST_LPX_OVR: assert property (ov && avs_address == 8'h48 |=>
		lp_exit_applied == wv_ff) else $error("lp exit override not applied");
	AST_HSZ_READ: assert property (rp && avs_address == 8'h45 |->
		avs_readdata[6:0] == hs_zero_applied) else $error("hs zero readback wrong");
	AST_LPX_READ: assert property (rp && avs_address == 8'h48 |->
		avs_readdata[6:0] == lp_exit_applied) else $error("lp exit readback wrong");
	cover property (ov);
	cover property (rp && avs_readdata[7]);
	cover property (wa && !avs_byteenable[0]);
endmodule // dptov_properties
bind dptov_regs dptov_properties u_chk (
	.mclk             (mclk),
	.rst_n            (rst_n),
	.avs_address      (avs_address),
	.avs_read         (avs_read),
	.avs_write        (avs_write),
	.avs_writedata    (avs_writedata),
	.avs_byteenable   (avs_byteenable),
	.avs_readdata     (avs_readdata),
	.avs_waitrequest  (avs_waitrequest),
	.hs_zero_applied  (hs_zero_applied),
	.hs_trail_applied (hs_trail_applied),
	.hs_exit_applied  (hs_exit_applied),
	.lp_exit_applied  (lp_exit_applied)
);
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timing override bank
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address, v;
	logic [31:0] avs_writedata, avs_readdata, seed, q[$];
	logic [3:0]  avs_byteenable;
	logic [6:0]  ap[4];
	logic [1:0]  rt;
	int          failures, n_checks;
	logic [31:0] tbl[4] = '{32'h0A060804, 32'h140B0F06, 32'h25141D0B, 32'h28151F0C};
	dptov_regs dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .hs_zero_applied(ap[0]),
		.hs_trail_applied(ap[1]), .hs_exit_applied(ap[2]), .lp_exit_applied(ap[3]));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] dv(input int i);
		return tbl[rt][31-8*i -: 8];
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask
	task automatic end_sim;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge mclk)
		if (avs_read && avs_waitrequest === 1'b0)
			chk(avs_readdata, q.pop_front());
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#2000000;
		failures++;
		end_sim();
	end
	initial begin
		seed = 32'hC22A2D92;
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		rt = 2'h0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rd(8'h45 + 8'(i), dv(i));
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, 8'h49, 8'(r));
			rt = 2'(r);
			for (int i = 0; i < 4; i++) rd(8'h45 + 8'(i), dv(i));
		end
		for (int i = 0; i < 4; i++) begin
			v = 8'($random(seed)) | 8'h80;
			bus(1'b1, 8'h45 + 8'(i), v & 8'h7F);
			rd(8'h45 + 8'(i), dv(i));
			bus(1'b1, 8'h45 + 8'(i), v);
			rd(8'h45 + 8'(i), v);
			chk({25'h0, ap[i]}, {25'h0, v[6:0]});
			bus(1'b1, 8'h45 + 8'(i), 8'h05);
			rd(8'h45 + 8'(i), dv(i));
			chk({25'h0, ap[i]}, {24'h0, dv(i)});
		end
		// lane 0 disabled, so the write must be dropped
		avs_byteenable <= 4'($random(seed)) & 4'hE;
		bus(1'b1, 8'h48, 8'hFF);
		avs_byteenable <= 4'hF;
		rd(8'h48, dv(3));
		bus(1'b1, 8'h4A, 8'h01);
		bus(1'b1, 8'h45, 8'h85);
		rd(8'h45, 8'h00);
		rd(8'h4A, 8'h01);
		bus(1'b1, 8'h4A, 8'h00);
		rd(8'h45, dv(0));
		rd(8'h60, 8'h00);
		rd(8'h49, 8'h03);
		rd(8'h4B, 8'h10);
		rd(8'h4B, 8'h00);
		bus(1'b1, 8'h46, 8'hC0);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rt = 2'h0;
		rd(8'h46, dv(1));
		repeat (2) @(posedge mclk);
		end_sim();
	end
endmodule // tb
`default_nettype wire
